// file: design/cnpc_ctrl.sv
// controlling end: apb registers driving the network's control and link ports
`timescale 1ns/10ps
`default_nettype none
module cnpc_ctrl import cnpc_pkg::*; #(
   parameter int RCFG_HALF = LINK_HALF,
   parameter bit RST_HIGH = 1'b1,
   parameter int HOLD_CNT = HOLD_CYCLES
)(
   input wire logic i_clk,
   input wire logic i_resetn,
   cnpc_if.ctl bus,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [APB_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   if (RCFG_HALF < 2 || HOLD_CNT < 2)
   begin : g_bad
      $error("link half period and hold count must be at least 2");
   end
   localparam int DW = $clog2(RCFG_HALF);
   localparam int HW = $clog2(HOLD_CNT + 1);
   localparam int SW = RCFG_DW + 4;

   // ---------------------------------------------------------------
   // status synchronisers and link clock
   // ---------------------------------------------------------------
   logic [SW-1:0] meta_q, sync_q;
   logic ack_s, done_s, lock_s, stop_s, stop_d_q;
   logic [RCFG_DW-1:0] rdat_s;
   always_ff @(posedge i_clk)
   begin
      meta_q <= {bus.reconfig_ack, bus.shift_complete, bus.locked, bus.ref_stopped,
                 bus.reconfig_rdata};
      sync_q <= meta_q;
      stop_d_q <= stop_s;
   end
   assign {ack_s, done_s, lock_s, stop_s, rdat_s} = sync_q;

   // one divided clock serves both link ports; strobes move on its fall
   logic [DW-1:0] div_q;
   logic lclk_q, fall;
   assign fall = (div_q == DW'(RCFG_HALF - 1)) & lclk_q;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn || div_q == DW'(RCFG_HALF - 1))
      begin
         div_q <= '0;
         lclk_q <= i_resetn ? ~lclk_q : 1'b0;
      end
      else
      begin
         div_q <= div_q + DW'(1);
      end
   end

   // ---------------------------------------------------------------
   // apb slave
   // ---------------------------------------------------------------
   logic acc, wr_acc;
   logic sel_q, psel_q, pdn_q, swrst_q, rst_q;
   logic [HW-1:0] hold_q;
   cnpc_xfer_t r_st_q, s_st_q;
   logic [RCFG_AW-1:0] raddr_q;
   logic rwr_q, rstb_q, sdir_q, sstb_q;
   logic [RCFG_DW-1:0] wdata_q, rdata_q;
   logic [31:0] rd_mux;
   logic hit;
   assign acc = i_psel & i_penable & o_pready;
   assign wr_acc = acc & i_pwrite;
   always_comb
   begin
      rd_mux = '0;
      hit = 1'b1;
      case (i_paddr)
         A_CTRL: rd_mux = 32'({swrst_q, pdn_q, sel_q});
         A_RCMD: rd_mux = 32'({rwr_q, 1'b0, raddr_q});
         A_RWDATA: rd_mux = 32'(wdata_q);
         A_RRDATA: rd_mux = 32'(rdata_q);
         A_SHIFT: rd_mux = 32'(sdir_q);
         A_STATUS: rd_mux = 32'({rst_q, s_st_q != X_IDLE, r_st_q != X_IDLE, stop_s, lock_s});
         default: hit = 1'b0;
      endcase
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         o_pready <= 1'b0;
         o_prdata <= '0;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready <= i_psel & i_penable & ~o_pready;
         o_prdata <= (i_psel & ~i_pwrite) ? rd_mux : 32'h0000_0000;
         o_pslverr <= i_psel & i_penable & ~o_pready & ~hit;
      end
   end

   // ---------------------------------------------------------------
   // control, source switch and network reset
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         sel_q <= CTRL_SEL_RESET;
         psel_q <= CTRL_SEL_RESET;
         pdn_q <= 1'b0;
         swrst_q <= 1'b0;
         hold_q <= '0;
         rst_q <= 1'b1;
      end
      else
      begin
         if (wr_acc && i_paddr == A_CTRL)
         begin
            pdn_q <= i_pwdata[CTRL_PDN];
            swrst_q <= i_pwdata[CTRL_RST];
            psel_q <= i_pwdata[CTRL_SEL];
            if (i_pwdata[CTRL_SEL] != psel_q)
            begin
               hold_q <= HW'(HOLD_CNT);
            end
         end
         else if (stop_d_q && !stop_s)
         begin
            hold_q <= HW'(HOLD_CNT);
         end
         else if (hold_q != '0)
         begin
            hold_q <= hold_q - HW'(1);
         end
         if (hold_q == HW'(HOLD_CNT / 2))
         begin
            sel_q <= psel_q;
         end
         rst_q <= swrst_q | (hold_q != '0);
      end
   end

   // ---------------------------------------------------------------
   // reconfiguration and shift sequencers
   // ---------------------------------------------------------------
   // a strobe stands from one link fall to the next, so the device
   // sees it on exactly one link rise
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         r_st_q <= X_IDLE;
         raddr_q <= '0;
         rwr_q <= 1'b0;
         wdata_q <= '0;
         rdata_q <= '0;
         rstb_q <= 1'b0;
      end
      else
      begin
         if (fall)
         begin
            rstb_q <= (r_st_q == X_ISSUE);
         end
         if (wr_acc && i_paddr == A_RWDATA && r_st_q == X_IDLE)
         begin
            wdata_q <= i_pwdata[RCFG_DW-1:0];
         end
         case (r_st_q)
            X_IDLE:
               if (wr_acc && i_paddr == A_RCMD)
               begin
                  raddr_q <= i_pwdata[RCFG_AW-1:0];
                  rwr_q <= i_pwdata[RCMD_WR];
                  r_st_q <= X_ISSUE;
               end
            X_ISSUE: if (fall) r_st_q <= X_WAIT;
            X_WAIT:
               if (ack_s)
               begin
                  rdata_q <= rwr_q ? rdata_q : rdat_s;
                  r_st_q <= X_DRAIN;
               end
            X_DRAIN: if (!ack_s) r_st_q <= X_IDLE;
            default: r_st_q <= X_IDLE;
         endcase
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         s_st_q <= X_IDLE;
         sdir_q <= 1'b0;
         sstb_q <= 1'b0;
      end
      else
      begin
         if (fall)
         begin
            sstb_q <= (s_st_q == X_ISSUE);
         end
         case (s_st_q)
            X_IDLE:
               if (wr_acc && i_paddr == A_SHIFT)
               begin
                  sdir_q <= i_pwdata[SHIFT_DIR];
                  s_st_q <= X_ISSUE;
               end
            X_ISSUE: if (fall) s_st_q <= X_WAIT;
            X_WAIT: if (done_s) s_st_q <= X_DRAIN;
            X_DRAIN: if (!done_s) s_st_q <= X_IDLE;
            default: s_st_q <= X_IDLE;
         endcase
      end
   end

   assign bus.reconfig_clock = lclk_q;
   assign bus.shift_clock = lclk_q;
   assign bus.reconfig_strobe = rstb_q;
   assign bus.reconfig_write = rwr_q;
   assign bus.reconfig_addr = raddr_q;
   assign bus.reconfig_wdata = wdata_q;
   assign bus.shift_strobe = sstb_q;
   assign bus.shift_direction = sdir_q;
   assign bus.src_select = sel_q;
   assign bus.power_down = pdn_q;
   assign bus.net_reset = RST_HIGH ? rst_q : ~rst_q;
endmodule : cnpc_ctrl
`default_nettype wire

// file: design/cnpc_device.sv
// clock network end: reference select, synthesized clocks, reconfig and shift ports
//
// Design decisions made here: the divider register map from DIV_BASE and the phase read at PHASE_ADDR.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - select high picks primary, low secondary
// - up to seven outputs, six with pll
// - per-output gate stops that output clock
// - per-output clear resets its divide counter
// - seven-bit address valid with strobe
// - strobe starts one reconfig transaction
// - controller drives write data with strobe
// - read data valid while ack high
// - ack marks end of each reconfig transaction
// - write flag picks write, else read
// - shift strobe starts one phase step
// - direction high increments, low decrements phase
// - shift complete marks end of step
// - network reset polarity is configurable
// - network reset clears state without clock
// - reset release restarts the lock sequence
// - power-down stops all output clocks
// - flag when selected reference stops toggling
// - lock only when outputs are stable
// - spread spectrum drops secondary, select, shift
// - spread spectrum drops outputs three and four
// - controller holds reset across source switch
// - controller resets after reference returns
module cnpc_device import cnpc_pkg::*; #(
   parameter int N_OUT = MAX_OUT_MMCX,
   parameter bit USE_PLL = 1'b0,
   parameter bit SPREAD = 1'b0,
   parameter bit RST_HIGH = 1'b1,
   parameter int LOCK_CNT = LOCK_CYCLES
)(
   input wire logic i_clk,
   input wire logic i_resetn,
   cnpc_if.dev bus,
   input wire logic i_primary_ref_clock,
   input wire logic i_secondary_ref_clock,
   input wire logic [N_OUT-1:0] i_output_buffer_gate,
   input wire logic [N_OUT-1:0] i_divider_counter_clear,
   output logic [N_OUT-1:0] o_synth_clock
);
   // ---------------------------------------------------------------
   // elaboration checks
   // ---------------------------------------------------------------
   localparam int MAXO = USE_PLL ? MAX_OUT_PLL : MAX_OUT_MMCX;
   if (N_OUT < 1 || N_OUT > MAXO)
   begin : g_bad_nout
      $error("output count out of range");
   end
   if (SPREAD && USE_PLL)
   begin : g_bad_ss
      $error("spread spectrum needs the mixed-mode primitive");
   end
   if (LOCK_CNT < 1)
   begin : g_bad_lock
      $error("lock count must be positive");
   end
   localparam int LCW = $clog2(LOCK_CNT + 1);
   localparam int SCW = $clog2(STOP_CYCLES + 1);
   localparam int SW = 2 * N_OUT + 10 + RCFG_AW + RCFG_DW;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // everything from pins but the network and device resets is re-timed as one vector so the strobes and
   // the link clocks keep their mutual alignment
   logic [SW-1:0] s_in;
   logic [SW-1:0] meta_q;
   logic [SW-1:0] sync_q;
   logic r1, r2, sel_raw, pdn, rclk, rstb_raw, rwr, sclk, sstb_raw, sdir;
   logic [RCFG_AW-1:0] raddr;
   logic [RCFG_DW-1:0] rwd;
   logic [N_OUT-1:0] gate;
   logic [N_OUT-1:0] clr;
   assign s_in = {i_primary_ref_clock, i_secondary_ref_clock, bus.src_select, bus.power_down,
                  bus.reconfig_clock, bus.reconfig_strobe, bus.reconfig_write,
                  bus.reconfig_addr, bus.reconfig_wdata, bus.shift_clock, bus.shift_strobe,
                  bus.shift_direction, i_output_buffer_gate, i_divider_counter_clear};
   always_ff @(posedge i_clk)
   begin
      meta_q <= s_in;
      sync_q <= meta_q;
   end
   assign {r1, r2, sel_raw, pdn, rclk, rstb_raw, rwr, raddr, rwd, sclk, sstb_raw, sdir,
           gate, clr} = sync_q;

   logic sel;
   logic sstb;
   assign sel = SPREAD ? 1'b1 : sel_raw;
   assign sstb = SPREAD ? 1'b0 : sstb_raw;

   logic rclk_d_q, sclk_d_q;
   logic rclk_rise, sclk_rise;
   always_ff @(posedge i_clk)
   begin
      rclk_d_q <= rclk;
      sclk_d_q <= sclk;
   end
   assign rclk_rise = rclk & ~rclk_d_q;
   assign sclk_rise = sclk & ~sclk_d_q;

   // ---------------------------------------------------------------
   // network reset and reference watch
   // ---------------------------------------------------------------
   logic net_rst;
   assign net_rst = RST_HIGH ? bus.net_reset : ~bus.net_reset;

   logic ref_sel;
   logic ref_d_q;
   logic ref_edge;
   logic [SCW-1:0] idle_cnt_q;
   logic stopped_q;
   assign ref_sel = sel ? r1 : r2;
   assign ref_edge = ref_sel ^ ref_d_q;
   always_ff @(posedge i_clk)
   begin
      ref_d_q <= ref_sel;
   end
   always_ff @(posedge i_clk or posedge net_rst)
   begin
      if (net_rst)
      begin
         idle_cnt_q <= '0;
         stopped_q <= 1'b0;
      end
      else if (!i_resetn || ref_edge)
      begin
         idle_cnt_q <= '0;
         stopped_q <= 1'b0;
      end
      else if (idle_cnt_q == SCW'(STOP_CYCLES))
      begin
         stopped_q <= 1'b1;
      end
      else
      begin
         idle_cnt_q <= idle_cnt_q + SCW'(1);
      end
   end

   // ---------------------------------------------------------------
   // lock sequence
   // ---------------------------------------------------------------
   // any source change, stall or power-down starts the count over
   logic sel_d_q;
   logic [LCW-1:0] lock_cnt_q;
   logic locked_q;
   always_ff @(posedge i_clk)
   begin
      sel_d_q <= sel;
   end
   always_ff @(posedge i_clk or posedge net_rst)
   begin
      if (net_rst)
      begin
         lock_cnt_q <= '0;
         locked_q <= 1'b0;
      end
      else if (!i_resetn || pdn || stopped_q || sel != sel_d_q)
      begin
         lock_cnt_q <= '0;
         locked_q <= 1'b0;
      end
      else if (lock_cnt_q == LCW'(LOCK_CNT))
      begin
         locked_q <= 1'b1;
      end
      else
      begin
         lock_cnt_q <= lock_cnt_q + LCW'(1);
      end
   end

   // ---------------------------------------------------------------
   // reconfiguration port
   // ---------------------------------------------------------------
   // the register image survives a network reset, like the real
   // configuration cells; only the device reset reloads it
   logic [RCFG_DW-1:0] cfg_q [2**RCFG_AW];
   logic [RCFG_DW-1:0] rdata_q;
   logic ack_q;
   logic [RCFG_DW-1:0] phase_q;
   logic r_go;
   assign r_go = rclk_rise & rstb_raw;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         for (int i = 0; i < 2**RCFG_AW; i++)
         begin
            cfg_q[i] <= DIV_RESET;
         end
      end
      else if (r_go && rwr && raddr != PHASE_ADDR)
      begin
         cfg_q[raddr] <= rwd;
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end
      else if (r_go)
      begin
         ack_q <= 1'b1;
         if (!rwr)
         begin
            rdata_q <= (raddr == PHASE_ADDR) ? phase_q : cfg_q[raddr];
         end
      end
      else if (rclk_rise)
      begin
         ack_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // dynamic phase shift
   // ---------------------------------------------------------------
   logic inc_q, dec_q;
   logic done_q;
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         inc_q <= 1'b0;
         dec_q <= 1'b0;
      end
      else
      begin
         inc_q <= sclk_rise & sstb & sdir;
         dec_q <= sclk_rise & sstb & ~sdir;
      end
   end
   always_ff @(posedge i_clk or posedge net_rst)
   begin
      if (net_rst)
      begin
         phase_q <= '0;
      end
      else if (!i_resetn)
      begin
         phase_q <= '0;
      end
      else if (inc_q)
      begin
         phase_q <= phase_q + RCFG_DW'(1);
      end
      else if (dec_q)
      begin
         phase_q <= phase_q - RCFG_DW'(1);
      end
   end
   always_ff @(posedge i_clk)
   begin
      if (!i_resetn)
      begin
         done_q <= 1'b0;
      end
      else if (inc_q || dec_q)
      begin
         done_q <= 1'b1;
      end
      else if (sclk_rise)
      begin
         done_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // synthesized outputs
   // ---------------------------------------------------------------
   // a phase step moves only the first output: increment stalls its
   // divider one cycle, decrement runs it two counts at once
   for (genvar k = 0; k < N_OUT; k++)
   begin : g_out
      localparam logic [RCFG_AW-1:0] ADR = RCFG_AW'(int'(DIV_BASE) + k);
      localparam bit GONE = SPREAD && (k == SS_GONE_A || k == SS_GONE_B);
      logic [HALF_W-1:0] cnt_q;
      logic clk_q;
      logic [HALF_W-1:0] half;
      logic [HALF_W:0] nxt;
      logic run;
      logic hold;
      assign half = (cfg_q[ADR][HALF_W-1:0] == '0) ? HALF_W'(1) : cfg_q[ADR][HALF_W-1:0];
      assign run = locked_q & ~pdn & gate[k] & ~GONE;
      assign hold = (k == 0) & inc_q;
      assign nxt = {1'b0, cnt_q} + (((k == 0) & dec_q) ? (HALF_W+1)'(2) : (HALF_W+1)'(1));
      always_ff @(posedge i_clk or posedge net_rst)
      begin
         if (net_rst)
         begin
            cnt_q <= '0;
            clk_q <= 1'b0;
         end
         else if (!i_resetn || clr[k])
         begin
            cnt_q <= '0;
            clk_q <= 1'b0;
         end
         else if (!run)
         begin
            clk_q <= 1'b0;
         end
         else if (!hold)
         begin
            if (nxt >= {1'b0, half})
            begin
               cnt_q <= '0;
               clk_q <= ~clk_q;
            end
            else
            begin
               cnt_q <= nxt[HALF_W-1:0];
            end
         end
      end
      assign o_synth_clock[k] = clk_q;
   end

   assign bus.reconfig_rdata = rdata_q;
   assign bus.reconfig_ack = ack_q;
   assign bus.shift_complete = done_q;
   assign bus.ref_stopped = stopped_q;
   assign bus.locked = locked_q;
endmodule : cnpc_device
`default_nettype wire

// file: design/cnpc_if.sv
// link between the clock network and its controlling logic
`timescale 1ns/10ps
`default_nettype none
interface cnpc_if import cnpc_pkg::*; ();
   logic reconfig_clock;
   logic reconfig_strobe;
   logic reconfig_write;
   logic [RCFG_AW-1:0] reconfig_addr;
   logic [RCFG_DW-1:0] reconfig_wdata;
   logic [RCFG_DW-1:0] reconfig_rdata;
   logic reconfig_ack;
   logic shift_clock;
   logic shift_strobe;
   logic shift_direction;
   logic shift_complete;
   logic src_select;
   logic net_reset;
   logic power_down;
   logic ref_stopped;
   logic locked;
   modport dev (
      input reconfig_clock, reconfig_strobe, reconfig_write, reconfig_addr, reconfig_wdata,
      input shift_clock, shift_strobe, shift_direction, src_select, net_reset, power_down,
      output reconfig_rdata, reconfig_ack, shift_complete, ref_stopped, locked
   );
   modport ctl (
      output reconfig_clock, reconfig_strobe, reconfig_write, reconfig_addr, reconfig_wdata,
      output shift_clock, shift_strobe, shift_direction, src_select, net_reset, power_down,
      input reconfig_rdata, reconfig_ack, shift_complete, ref_stopped, locked
   );
endinterface : cnpc_if
`default_nettype wire

// file: design/cnpc_pkg.sv
// shared constants and types for the clock network port control ends
package cnpc_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 25;
   localparam int LOCK_TIME_US = 100;
   localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
   localparam int STOP_TIME_NS = 2000;
   localparam int STOP_CYCLES = (STOP_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_TIME_NS = 400;
   localparam int HOLD_CYCLES = (HOLD_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int LINK_HALF = 4;
   // ---------------------------------------------------------------
   // reconfiguration port
   // ---------------------------------------------------------------
   localparam int RCFG_AW = 7;
   localparam int RCFG_DW = 16;
   localparam int HALF_W = 8;
   localparam int MAX_OUT_MMCX = 7;
   localparam int MAX_OUT_PLL = 6;
   localparam int SS_GONE_A = 2;
   localparam int SS_GONE_B = 3;
   localparam logic [RCFG_AW-1:0] DIV_BASE = 7'h08;
   localparam logic [RCFG_AW-1:0] PHASE_ADDR = 7'h7f;
   localparam logic [RCFG_DW-1:0] DIV_RESET = 16'h0001;
   // ---------------------------------------------------------------
   // controller registers (apb, byte addresses)
   // ---------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] A_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] A_RCMD = 8'h04;
   localparam logic [APB_AW-1:0] A_RWDATA = 8'h08;
   localparam logic [APB_AW-1:0] A_RRDATA = 8'h0c;
   localparam logic [APB_AW-1:0] A_SHIFT = 8'h10;
   localparam logic [APB_AW-1:0] A_STATUS = 8'h14;
   localparam int CTRL_SEL = 0;
   localparam int CTRL_PDN = 1;
   localparam int CTRL_RST = 2;
   localparam int RCMD_WR = 8;
   localparam int SHIFT_DIR = 0;
   localparam int ST_LOCK = 0;
   localparam int ST_STOP = 1;
   localparam int ST_RBUSY = 2;
   localparam int ST_SBUSY = 3;
   localparam int ST_RST = 4;
   localparam logic CTRL_SEL_RESET = 1'b1;
   typedef enum {X_IDLE, X_ISSUE, X_WAIT, X_DRAIN} cnpc_xfer_t;
endpackage : cnpc_pkg

// file: verif/cnpc_monitor.sv
// assertion checker on the link between controller and network
`timescale 1ns/10ps
`default_nettype none
module cnpc_monitor (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic reconfig_strobe,
   input wire logic reconfig_write,
   input wire logic [6:0] reconfig_addr,
   input wire logic [15:0] reconfig_wdata,
   input wire logic reconfig_ack,
   input wire logic shift_strobe,
   input wire logic shift_complete,
   input wire logic src_select,
   input wire logic net_reset,
   input wire logic locked
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   sequence s_start;
      $rose(reconfig_strobe);
   endsequence
   // strobe spans one whole link period
   sequence s_pulse;
      reconfig_strobe [*8] ##1 !reconfig_strobe;
   endsequence
   strobe_width_a: assert property (s_start |-> s_pulse)
      else $error("strobe width");
   req_hold_a: assert property ($past(reconfig_strobe) && reconfig_strobe |->
      $stable({reconfig_write, reconfig_addr, reconfig_wdata}))
      else $error("request moved");
   ack_bound_a: assert property (s_start |-> ##[1:40] reconfig_ack)
      else $error("no ack");
   one_open_a: assert property (s_start |-> !reconfig_ack)
      else $error("overlap");
   shift_done_a: assert property ($rose(shift_strobe) |-> ##[1:40] shift_complete)
      else $error("no shift done");
   reset_unlock_a: assert property (net_reset |-> !locked)
      else $error("lock in reset");
   relock_wait_a: assert property ($fell(net_reset) |-> !locked [*8])
      else $error("early lock");
   switch_reset_a: assert property ($changed(src_select) |-> net_reset)
      else $error("switch out of reset");
endmodule : cnpc_monitor
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench joining controller and network ends
`timescale 1ns/10ps
`default_nettype none
module testbench import cnpc_pkg::*;;
   logic i_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] padr = 8'h00;
   logic [31:0] pwd = 32'h0;
   logic [31:0] prd;
   logic [31:0] rd;
   logic pready;
   logic perr;
   logic err;
   logic acc;
   logic stop_q = 1'b0;
   logic [2:0] div_q = 3'h0;
   logic [6:0] gate = 7'h7f;
   logic [6:0] clr = 7'h00;
   logic [6:0] sclk;
   int mismatches = 0;
   int n_compared = 0;
   // slow references so the two-flop samplers see every edge
   wire pri = div_q[2] & ~stop_q;
   wire sec = div_q[1];
   cnpc_if bus ();
   always #20 i_clk = ~i_clk;
   always @(posedge i_clk) div_q <= div_q + 3'h1;
   cnpc_device #(.LOCK_CNT(20)) u_cnpc_device (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus),
      .i_primary_ref_clock(pri), .i_secondary_ref_clock(sec), .i_output_buffer_gate(gate),
      .i_divider_counter_clear(clr), .o_synth_clock(sclk));
   cnpc_ctrl u_cnpc_ctrl (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
      .o_pready(pready), .o_pslverr(perr));
   cnpc_monitor u_cnpc_monitor (.i_clk(i_clk), .i_resetn(i_resetn),
      .reconfig_strobe(bus.reconfig_strobe), .reconfig_write(bus.reconfig_write),
      .reconfig_addr(bus.reconfig_addr), .reconfig_wdata(bus.reconfig_wdata),
      .reconfig_ack(bus.reconfig_ack), .shift_strobe(bus.shift_strobe),
      .shift_complete(bus.shift_complete), .src_select(bus.src_select),
      .net_reset(bus.net_reset), .locked(bus.locked));
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : conclude
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s exp %h got %h", s, e, g);
      end
   endtask : chk
   // the idle edge first keeps back-to-back calls from driving psel twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge i_clk);
      pen <= 1'b1;
      do @(posedge i_clk); while (pready !== 1'b1);
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic st(input int b, input logic v);
      do apb(1'b0, A_STATUS, 32'h0); while (rd[b] !== v);
   endtask : st
   task automatic rcfg(input logic [31:0] c);
      apb(1'b1, A_RCMD, c);
      st(ST_RBUSY, 1'b0);
      apb(1'b0, A_RRDATA, 32'h0);
   endtask : rcfg
   task automatic sample(input int k);
      acc = 1'b0;
      repeat (3) @(posedge i_clk);
      repeat (8)
      begin
         @(posedge i_clk);
         acc = acc | sclk[k];
      end
   endtask : sample
   task automatic t_regs();
      apb(1'b0, A_CTRL, 32'h0);
      chk("ctrl sel", 32'h1, 32'(rd[0]));
      apb(1'b0, 8'h1c, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      $display("regs done");
   endtask : t_regs
   task automatic t_out();
      st(ST_LOCK, 1'b1);
      acc = sclk[0];
      @(posedge i_clk);
      chk("toggle", 32'(!acc), 32'(sclk[0]));
      gate <= 7'h7d;
      sample(1);
      chk("gated", 32'h0, 32'(acc));
      gate <= 7'h7f;
      clr <= 7'h04;
      sample(2);
      chk("cleared", 32'h0, 32'(acc));
      clr <= 7'h00;
      apb(1'b1, A_CTRL, 32'h3);
      sample(0);
      chk("pdown", 32'h0, 32'(acc));
      apb(1'b1, A_CTRL, 32'h1);
      st(ST_LOCK, 1'b1);
      $display("outputs done");
   endtask : t_out
   task automatic t_rcfg();
      rcfg(32'h10);
      chk("rdata reset", 32'(DIV_RESET), rd);
      rcfg(32'h110);
      rcfg(32'h10);
      chk("rdata zero", 32'h0, rd);
      apb(1'b1, A_RWDATA, 32'ha5c3);
      rcfg(32'h110);
      rcfg(32'h10);
      chk("readback", 32'ha5c3, rd);
      apb(1'b1, A_SHIFT, 32'h1);
      st(ST_SBUSY, 1'b0);
      rcfg(32'h7f);
      chk("phase up", 32'h1, rd);
      apb(1'b1, A_SHIFT, 32'h0);
      st(ST_SBUSY, 1'b0);
      rcfg(32'h7f);
      chk("phase down", 32'h0, rd);
      $display("reconfig done");
   endtask : t_rcfg
   task automatic t_src();
      stop_q <= 1'b1;
      st(ST_STOP, 1'b1);
      stop_q <= 1'b0;
      st(ST_STOP, 1'b0);
      st(ST_LOCK, 1'b1);
      apb(1'b1, A_CTRL, 32'h0);
      repeat (16) @(posedge i_clk);
      st(ST_LOCK, 1'b1);
      chk("select", 32'h0, 32'(bus.src_select));
      stop_q <= 1'b1;
      repeat (80) @(posedge i_clk);
      apb(1'b0, A_STATUS, 32'h0);
      chk("sec ok", 32'h1, rd & 32'h3);
      $display("source done");
   endtask : t_src
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      t_regs();
      t_out();
      t_rcfg();
      t_src();
      conclude();
   end
   // the tests need well under two thousand cycles; this leaves wide margin
   initial
   begin
      #2000000;
      mismatches++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
